//--- hw/kwu_defs.svh
// Purpose: constants of the keypad wake unit
// Assumes: included by its bare name
// Notes: byte offsets on a 32-bit APB, 8-bit registers in the low bits
`ifndef KWU_DEFS_SVH
`define KWU_DEFS_SVH
// ==========================================================
// register byte offsets
`define KWU_OFS_SC 8'h00
`define KWU_OFS_PE 8'h04
`define KWU_OFS_ES 8'h08
`define KWU_OFS_GATE 8'h0C
`define KWU_OFS_EVT 8'h10
`define KWU_OFS_MASK 8'h14
// ==========================================================
// status and control field positions
`define KWU_SC_FLAG 3
`define KWU_SC_ACK 2
`define KWU_SC_IE 1
`define KWU_SC_MODE 0
// event status fields
`define KWU_EVT_FLAG 0
`define KWU_EVT_WAKE 1
// clock gate word field
`define KWU_GATE_BIT 0
// ==========================================================
// widths and reset values
`define KWU_PIN_COUNT 8
`define KWU_HALF_PINS 4
`define KWU_EVT_W 2
`define KWU_RST_BYTE 8'h00
`define KWU_RST_PREV 8'hFF
`define KWU_RST_EVT 2'h0
`define KWU_RST_GATE 1'h1
`endif

//--- hw/kwu_pkg.sv
// Purpose: types of the keypad wake unit
// Assumes: nothing
// Notes: used by package::name only
package kwu_pkg;
    // ==========================================================
    // register select
    typedef enum logic [2:0] {
        REG_SC, REG_PE, REG_ES, REG_GATE, REG_EVT, REG_MASK, REG_NONE
    } kwu_reg_t;
    // power state of the controller
    typedef enum logic [1:0] {
        PWR_RUN, PWR_WAIT, PWR_RETAINED, PWR_DEEPEST
    } kwu_power_t;
    // apb request as seen by the slave
    typedef struct packed {
        logic sel;
        logic enable;
        logic write;
        logic [7:0] addr;
        logic [31:0] wdata;
    } kwu_apb_req_t;
endpackage

//--- hw/kwu_top.sv
// Purpose: keypad wake unit, eight pin edge/level interrupt and wake source
// Assumes: pins synchronous to ref_clk; APB slave, zero wait state
// Notes: deepest sleep holds all state at reset values except the gate, event status and event mask words
// Summary of operation
// - eight individually enabled pins feed one shared software-enabled interrupt
// - a clock gate bit, set after reset, freezes the unit when cleared
// - each pin detects edge only, or edge plus level
// - in wait mode the unit keeps running and wakes when enabled
// - in retained sleep an asserted enabled pin wakes when enabled
// - deepest sleep disables the unit and returns it to reset, except the gate, event status and event mask words
// - background debug does not change detection or flag behaviour
// - inputs 0-3 are port A bits 0-3, 4-7 port B bits 0-3
// - three 8-bit registers: status/control, pin enable, polarity select
// - status bit 3 is a read-only detect flag; writes ignored
// - status bit 2 is acknowledge; writing 1 clears flag, reads 0
// - status bit 1 enables the interrupt request
// - status bit 0 selects edge only or edge plus level
// - edges are seen from one sample to the next on enabled pins
// - polarity 0 falling/low with pullup, 1 rising/high with pulldown
// - in level mode acknowledge clears only if enabled pins are deasserted
// - pin enable bit 1 includes that pin, 0 excludes it
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "kwu_defs.svh"
module kwu_top #(
    parameter int ADDR_W = 8
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] port_a_pins,
    input wire logic [3:0] port_b_pins,
    input wire logic wait_mode,
    input wire logic retained_state_sleep,
    input wire logic deepest_sleep,
    output logic cpu_irq,
    output logic wake_request,
    output logic irq,
    output logic [7:0] pull_up_select,
    output logic [7:0] pull_down_select
);
    // ==========================================================
    // declarations
    localparam int NP = `KWU_PIN_COUNT;
    kwu_pkg::kwu_apb_req_t req;
    kwu_pkg::kwu_power_t power;
    kwu_pkg::kwu_reg_t rd_sel;
    kwu_pkg::kwu_reg_t wr_sel;
    logic [NP-1:0] wake_in;
    logic [NP-1:0] asserted;
    logic [NP-1:0] prev_asserted;
    logic [NP-1:0] edge_hit;
    logic [NP-1:0] level_hit;
    logic [NP-1:0] pin_source_enable_reg;
    logic [NP-1:0] pin_polarity_select_reg;
    logic irq_request_enable;
    logic detect_level_mode;
    logic detect_flag;
    logic clock_gate_on;
    logic [`KWU_EVT_W-1:0] evt_status;
    logic [`KWU_EVT_W-1:0] evt_mask;
    logic [`KWU_EVT_W-1:0] evt_set;
    logic wr_acc;
    logic active;
    logic any_hit;
    logic any_asserted;
    logic flag_ack;
    logic next_wake;

    // ==========================================================
    // decode helpers
    function automatic kwu_pkg::kwu_reg_t reg_decode(input logic [7:0] a);
        case (a)
            `KWU_OFS_SC: reg_decode = kwu_pkg::REG_SC;
            `KWU_OFS_PE: reg_decode = kwu_pkg::REG_PE;
            `KWU_OFS_ES: reg_decode = kwu_pkg::REG_ES;
            `KWU_OFS_GATE: reg_decode = kwu_pkg::REG_GATE;
            `KWU_OFS_EVT: reg_decode = kwu_pkg::REG_EVT;
            `KWU_OFS_MASK: reg_decode = kwu_pkg::REG_MASK;
            default: reg_decode = kwu_pkg::REG_NONE;
        endcase
    endfunction

    // per pin asserted level from polarity
    function automatic logic [NP-1:0] level_of(input logic [NP-1:0] pins,
                                               input logic [NP-1:0] pol);
        level_of = ~(pins ^ pol);
    endfunction

    // ==========================================================
    // bus request and power state
    assign req.sel = psel;
    assign req.enable = penable;
    assign req.write = pwrite;
    assign req.addr = 8'(paddr);
    assign req.wdata = pwdata;
    assign rd_sel = reg_decode(req.addr);
    assign wr_sel = reg_decode(req.addr);
    assign wr_acc = req.sel && req.enable && req.write && pready;

    // power state from the mode inputs, deepest wins
    always_comb
    begin
        if (deepest_sleep)
            power = kwu_pkg::PWR_DEEPEST;
        else if (retained_state_sleep)
            power = kwu_pkg::PWR_RETAINED;
        else if (wait_mode)
            power = kwu_pkg::PWR_WAIT;
        else
            power = kwu_pkg::PWR_RUN;
    end

    // unit runs while clock gate is on and not in deepest sleep; debug mode has no input here
    assign active = clock_gate_on && (power != kwu_pkg::PWR_DEEPEST);

    // ==========================================================
    // pin mapping and detection
    assign wake_in = {port_b_pins, port_a_pins};
    assign asserted = level_of(wake_in, pin_polarity_select_reg);

    // per pin edge and level terms
    genvar gi;
    generate
        for (gi = 0; gi < NP; gi++)
        begin : g_pin
            assign edge_hit[gi] = pin_source_enable_reg[gi] && asserted[gi]
                && !prev_asserted[gi];
            assign level_hit[gi] = pin_source_enable_reg[gi] && asserted[gi]
                && (detect_level_mode
                    || power == kwu_pkg::PWR_RETAINED);
        end
    endgenerate

    assign any_hit = |(edge_hit | level_hit);
    assign any_asserted = |(pin_source_enable_reg & asserted);
    assign flag_ack = wr_acc && wr_sel == kwu_pkg::REG_SC
        && req.wdata[`KWU_SC_ACK] && clock_gate_on;

    // previous sample, starts asserted so no edge before a deasserted sample
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            prev_asserted <= `KWU_RST_PREV;
        else if (power == kwu_pkg::PWR_DEEPEST)
            prev_asserted <= `KWU_RST_PREV;
        else if (active)
            prev_asserted <= asserted;
    end

    // ==========================================================
    // detect flag, set wins over acknowledge
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            detect_flag <= 1'b0;
        else if (power == kwu_pkg::PWR_DEEPEST)
            detect_flag <= 1'b0;
        else if (active && any_hit)
            detect_flag <= 1'b1;
        else if (flag_ack && !(detect_level_mode && any_asserted))
            detect_flag <= 1'b0;
    end

    // ==========================================================
    // software registers
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            irq_request_enable <= 1'b0;
            detect_level_mode <= 1'b0;
            pin_source_enable_reg <= `KWU_RST_BYTE;
            pin_polarity_select_reg <= `KWU_RST_BYTE;
        end
        else if (power == kwu_pkg::PWR_DEEPEST)
        begin
            irq_request_enable <= 1'b0;
            detect_level_mode <= 1'b0;
            pin_source_enable_reg <= `KWU_RST_BYTE;
            pin_polarity_select_reg <= `KWU_RST_BYTE;
        end
        else if (wr_acc && clock_gate_on)
        begin
            case (wr_sel)
                kwu_pkg::REG_SC:
                begin
                    irq_request_enable <= req.wdata[`KWU_SC_IE];
                    detect_level_mode <= req.wdata[`KWU_SC_MODE];
                end
                kwu_pkg::REG_PE: pin_source_enable_reg <= req.wdata[NP-1:0];
                kwu_pkg::REG_ES: pin_polarity_select_reg <= req.wdata[NP-1:0];
                default: ;
            endcase
        end
    end

    // clock gate bit, set after every reset
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            clock_gate_on <= `KWU_RST_GATE;
        else if (wr_acc && wr_sel == kwu_pkg::REG_GATE)
            clock_gate_on <= req.wdata[`KWU_GATE_BIT];
    end

    // ==========================================================
    // event status, write one to clear, set wins
    assign evt_set = {next_wake && !wake_request, active && any_hit && !detect_flag};
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            evt_status <= `KWU_RST_EVT;
            evt_mask <= `KWU_RST_EVT;
        end
        else
        begin
            if (wr_acc && wr_sel == kwu_pkg::REG_EVT)
                evt_status <= (evt_status & ~req.wdata[`KWU_EVT_W-1:0]) | evt_set;
            else
                evt_status <= evt_status | evt_set;
            if (wr_acc && wr_sel == kwu_pkg::REG_MASK)
                evt_mask <= req.wdata[`KWU_EVT_W-1:0];
        end
    end

    // ==========================================================
    // request outputs
    assign next_wake = irq_request_enable && (power == kwu_pkg::PWR_WAIT
        || power == kwu_pkg::PWR_RETAINED) && detect_flag;
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cpu_irq <= 1'b0;
            wake_request <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            cpu_irq <= detect_flag && irq_request_enable;
            wake_request <= next_wake;
            irq <= |(evt_status & evt_mask);
        end
    end

    // pull direction follows polarity
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pull_up_select <= ~`KWU_RST_BYTE;
            pull_down_select <= `KWU_RST_BYTE;
        end
        else
        begin
            pull_up_select <= ~pin_polarity_select_reg;
            pull_down_select <= pin_polarity_select_reg;
        end
    end

    // ==========================================================
    // apb answer, one wait-free access phase
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else
        begin
            pready <= req.sel && !req.enable;
            pslverr <= req.sel && !req.enable && rd_sel == kwu_pkg::REG_NONE;
            case (rd_sel)
                kwu_pkg::REG_SC: prdata <= 32'({detect_flag, 1'b0,
                    irq_request_enable, detect_level_mode});
                kwu_pkg::REG_PE: prdata <= 32'(pin_source_enable_reg);
                kwu_pkg::REG_ES: prdata <= 32'(pin_polarity_select_reg);
                kwu_pkg::REG_GATE: prdata <= 32'(clock_gate_on);
                kwu_pkg::REG_EVT: prdata <= 32'(evt_status);
                kwu_pkg::REG_MASK: prdata <= 32'(evt_mask);
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    a_flag_on_hit: assert property (active && any_hit |=> detect_flag)
        else $error("flag not set on detected activity");
    a_ack_reads_zero: assert property (pready && rd_sel == kwu_pkg::REG_SC
        |-> !prdata[`KWU_SC_ACK])
        else $error("acknowledge bit read as one");
    a_flag_write_ignored: assert property (!detect_flag && !(active && any_hit)
        |=> !detect_flag)
        else $error("flag set without activity");
    a_level_hold_flag: assert property (flag_ack && detect_level_mode
        && any_asserted && detect_flag && active |=> detect_flag)
        else $error("flag cleared while pin asserted");
    a_edge_ack_clear: assert property (flag_ack && !detect_level_mode
        && !(active && any_hit) && power != kwu_pkg::PWR_DEEPEST |=> !detect_flag)
        else $error("acknowledge did not clear flag");
    a_cpu_irq_cause: assert property (cpu_irq |-> $past(detect_flag)
        && $past(irq_request_enable))
        else $error("cpu request without flag and enable");
    a_deep_reset: assert property (deepest_sleep |=> !detect_flag
        && pin_source_enable_reg == `KWU_RST_BYTE && !irq_request_enable)
        else $error("state kept in deepest sleep");
    a_gate_freeze: assert property (!clock_gate_on && !detect_flag
        |=> !detect_flag)
        else $error("flag set with clock gated");
    a_wake_in_wait: assert property (wait_mode && !retained_state_sleep
        && !deepest_sleep && detect_flag && irq_request_enable
        ##1 detect_flag && wait_mode |-> wake_request)
        else $error("no wake in wait mode");
    a_pull_select: assert property (##1 pull_up_select == ~pull_down_select)
        else $error("pull selects overlap");
    a_apb_answer: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("apb answer timing wrong");

    c_edge_flag: cover property (!detect_level_mode && !detect_flag ##1 detect_flag);
    c_level_hold: cover property (flag_ack && detect_level_mode && any_asserted);
    c_retained_wake: cover property (retained_state_sleep && wake_request);
    c_event_irq: cover property (irq);
endmodule // kwu_top
`default_nettype wire

//--- tb/kwu_switch_model.sv
// Purpose: switches on the eight wake inputs of the keypad wake unit
// Assumes: one switch per input, closing to the rail opposite the pull
// Notes: a released input settles to its pull level, never to the last driven value
`timescale 1ns/10ps
`default_nettype none
module kwu_switch_model (
    input wire logic [7:0] press,
    input wire logic [7:0] pull_up_select,
    input wire logic [7:0] pull_down_select,
    output logic [3:0] port_a_pins,
    output logic [3:0] port_b_pins
);
    logic [7:0] level;
    // pressed shorts to the far rail, released follows the selected pull
    assign level = (press & pull_down_select) | (~press & pull_up_select);
    // inputs 0-3 on port a, 4-7 on port b
    assign port_a_pins = level[3:0];
    assign port_b_pins = level[7:4];
endmodule // kwu_switch_model
`default_nettype wire

//--- tb/tb_top.sv
// Purpose: register level tests of the keypad wake unit
// Assumes: zero or more apb wait states, switch model on the pins
// Notes: expected values are built from the register layout only
`timescale 1ns/10ps
`default_nettype none
`include "kwu_defs.svh"
module tb_top;
    logic ref_clk = 1'h0;
    logic reset_n = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, cpu_irq, wake_request, irq;
    logic [3:0] port_a_pins, port_b_pins;
    logic wait_mode = 1'h0;
    logic retained_state_sleep = 1'h0;
    logic deepest_sleep = 1'h0;
    logic [7:0] pull_up_select, pull_down_select;
    logic [7:0] press = 8'h00;
    logic [31:0] rd;
    logic err;
    int fails = 0;
    int checked = 0;
    // ==========================================================
    // clock, design and switches
    always #20 ref_clk = ~ref_clk;
    kwu_top i_kwu_top (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .port_a_pins(port_a_pins), .port_b_pins(port_b_pins),
        .wait_mode(wait_mode), .retained_state_sleep(retained_state_sleep),
        .deepest_sleep(deepest_sleep), .cpu_irq(cpu_irq), .wake_request(wake_request),
        .irq(irq), .pull_up_select(pull_up_select), .pull_down_select(pull_down_select));
    kwu_switch_model i_kwu_switch_model (.press(press), .pull_up_select(pull_up_select),
        .pull_down_select(pull_down_select), .port_a_pins(port_a_pins),
        .port_b_pins(port_b_pins));
    // ==========================================================
    // bench tasks
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // one apb transfer: setup, then access until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'h1;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'h1 && n < 20);
        rd = prdata;
        err = pslverr;
        if (n >= 20)
            chk("pready wait", 32'h0, 32'h1);
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        chk(nm, rd, exp);
    endtask
    // ==========================================================
    // hang guard
    initial
    begin
        cyc(20000);
        fails++;
        tally_and_finish();
    end
    // ==========================================================
    // test sequence
    initial
    begin
        logic [7:0] pol;
        cyc(6);
        reset_n <= 1'h1;
        // reset values of all six words, gate word reads one
        for (int k = 0; k < 6; k++)
            rdc("reset value", 8'(k * 4), (k == 3) ? 32'h1 : 32'h0);
        chk("pull up after reset", {24'h0, pull_up_select}, 32'hFF);
        apb(1'h0, 8'h18, 32'h0);
        chk("unmapped error", {31'h0, err}, 32'h1);
        // each input alone, alternating polarity, a disabled neighbour first
        for (int i = 0; i < 8; i++)
        begin
            pol = (i % 2) ? 8'(1 << i) : 8'h00;
            wr(`KWU_OFS_ES, {24'h0, pol});
            wr(`KWU_OFS_PE, 32'(1 << i));
            wr(`KWU_OFS_SC, 32'h04);
            chk("pull down select", {24'h0, pull_down_select}, {24'h0, pol});
            press <= 8'(1 << ((i + 1) % 8));
            cyc(4);
            press <= 8'h00;
            cyc(3);
            rdc("flag from disabled pin", `KWU_OFS_SC, 32'h00);
            press <= 8'(1 << i);
            cyc(4);
            rdc("flag after edge", `KWU_OFS_SC, 32'h08);
            chk("request with enable off", {31'h0, cpu_irq}, 32'h0);
        end
        // pin 7 rising, interrupt enabled; flag bit is not writable
        press <= 8'h00;
        wr(`KWU_OFS_SC, 32'h06);
        wr(`KWU_OFS_SC, 32'h0A);
        cyc(2);
        rdc("flag write ignored", `KWU_OFS_SC, 32'h02);
        chk("request after ack", {31'h0, cpu_irq}, 32'h0);
        press <= 8'h80;
        cyc(4);
        chk("cpu request", {31'h0, cpu_irq}, 32'h1);
        rdc("flag set event", `KWU_OFS_EVT, 32'h1);
        chk("irq masked", {31'h0, irq}, 32'h0);
        wr(`KWU_OFS_MASK, 32'h1);
        cyc(2);
        chk("irq unmasked", {31'h0, irq}, 32'h1);
        wr(`KWU_OFS_EVT, 32'h1);
        cyc(2);
        chk("irq after clear", {31'h0, irq}, 32'h0);
        wait_mode <= 1'h1;
        cyc(3);
        chk("wake in wait", {31'h0, wake_request}, 32'h1);
        rdc("wake rising event", `KWU_OFS_EVT, 32'h2);
        wait_mode <= 1'h0;
        press <= 8'h00;
        wr(`KWU_OFS_SC, 32'h06);
        cyc(3);
        chk("request cleared", {31'h0, cpu_irq}, 32'h0);
        // retained sleep: an asserted enabled input wakes
        retained_state_sleep <= 1'h1;
        press <= 8'h80;
        cyc(4);
        chk("wake in retained sleep", {31'h0, wake_request}, 32'h1);
        retained_state_sleep <= 1'h0;
        press <= 8'h00;
        // level mode: ack refused while the input is held
        wr(`KWU_OFS_SC, 32'h07);
        press <= 8'h80;
        cyc(4);
        wr(`KWU_OFS_SC, 32'h07);
        cyc(2);
        rdc("flag held by level", `KWU_OFS_SC, 32'h0B);
        press <= 8'h00;
        cyc(2);
        wr(`KWU_OFS_SC, 32'h07);
        cyc(2);
        rdc("flag cleared at rest", `KWU_OFS_SC, 32'h03);
        // clock gate off: no detection, control writes ignored
        wr(`KWU_OFS_GATE, 32'h0);
        press <= 8'h80;
        cyc(4);
        wr(`KWU_OFS_SC, 32'h00);
        rdc("gated unit", `KWU_OFS_SC, 32'h03);
        press <= 8'h00;
        wr(`KWU_OFS_GATE, 32'h1);
        // deepest sleep returns pin enable, control and polarity to reset values
        deepest_sleep <= 1'h1;
        cyc(2);
        wr(`KWU_OFS_PE, 32'h55);
        rdc("deepest pin enable", `KWU_OFS_PE, 32'h0);
        rdc("deepest control", `KWU_OFS_SC, 32'h0);
        rdc("deepest polarity", `KWU_OFS_ES, 32'h0);
        deepest_sleep <= 1'h0;
        cyc(2);
        tally_and_finish();
    end
endmodule // tb_top
`default_nettype wire
